// [hw/pfgam_defs.vh]
/*
  Constants for the eight-bit general-purpose port with analog sharing:
  register offsets, field positions, reset values and decode thresholds.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef PFGAM_DEFS_VH
`define PFGAM_DEFS_VH

// ==========================================================================
// Register byte offsets on the APB window
`define PFGAM_OFS_PIN_VALUE      12'h000
`define PFGAM_OFS_OUTPUT_LATCH   12'h004
`define PFGAM_OFS_DIRECTION      12'h008
`define PFGAM_OFS_ADC_PIN_CFG    12'h00C
`define PFGAM_OFS_CMP_CONTROL    12'h010
`define PFGAM_OFS_CMP_VREF_CTRL  12'h014

// ==========================================================================
// Reset values
`define PFGAM_RST_LATCH          8'h00
`define PFGAM_RST_DIRECTION      8'hFF
`define PFGAM_RST_ADC_PIN_CFG    6'h00
`define PFGAM_RST_CMP_CONTROL    6'h07
`define PFGAM_RST_VREF_CTRL      8'h00

// ==========================================================================
// Field positions and widths
`define PFGAM_ADC_CFG_W          6
`define PFGAM_PCFG_MSB           3
`define PFGAM_CMP_CFG_W          6
`define PFGAM_CMP_MODE_MSB       2
`define PFGAM_CMP_SECOND_COMPARATOR_OUTPUT_BIT      7
`define PFGAM_CMP_FIRST_COMPARATOR_OUTPUT_BIT      6
`define PFGAM_VREF_OE_BIT        6
`define PFGAM_VREF_PIN           5
`define PFGAM_SS_PIN             7
`define PFGAM_SECOND_COMPARATOR_OUTPUT_PIN          1
`define PFGAM_FIRST_COMPARATOR_OUTPUT_PIN          2

// ==========================================================================
// Decode constants
`define PFGAM_FIRST_CHANNEL      4'h5
`define PFGAM_LAST_ANALOG_CODE   5'h0E
`define PFGAM_CMP_MODE_OFF       3'h7
`define PFGAM_CMP_MODE_BOTH_OUT  3'h3
`define PFGAM_CMP_MODE_C1_OUT    3'h5

`endif

// [hw/pfgam_port.v]
/*
  Eight-bit bidirectional port with per-pin direction, output latch and
  pin readback, sharing its pins with converter channels, comparator
  inputs and outputs, the comparator reference output and a serial
  slave-select input. Registers are reached over APB.
  Assumes pin levels and comparator results arrive asynchronously and are
  synchronised here; the converter, comparators and serial port live
  outside and use the enables and configuration driven from here.
*/
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps

`include "pfgam_defs.vh"

module pfgam_port
#(
  parameter WIDE_VARIANT = 1
)
(
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  pin_in,
  output reg  [7:0]  pin_out,
  output reg  [7:0]  pin_oe,
  input  wire        first_comparator_output,
  input  wire        second_comparator_output,
  output reg  [7:0]  analog_enable,
  output reg  [3:0]  comparator_input_connect,
  output reg  [5:0]  comparator_config,
  output reg  [7:0]  vref_config,
  output reg         vref_output_enable,
  output reg         serial_slave_select
);

  // ========================================================================
  // Decode functions
  // Channel 5+n on pin n is analog while the pin-config code is at most 14-(5+n);
  // code 0 makes pins 0 to 6 analog (pin 7 never is), code 0Fh makes all digital.
  function [6:0] pcfg_analog;
    input [3:0] pin_config;
    integer     n;
    reg   [4:0] chan;
    begin
      pcfg_analog = 7'h00;
      for (n = 0; n < 7; n = n + 1)
      begin
        chan = {1'b0, `PFGAM_FIRST_CHANNEL} + n[4:0];
        pcfg_analog[n] = ({1'b0, pin_config} + chan) <= `PFGAM_LAST_ANALOG_CODE;
      end
    end
  endfunction

  // Which comparator outputs reach their pins, {second, first}
  function [1:0] cmp_routed;
    input [2:0] mode;
    begin
      case (mode)
        `PFGAM_CMP_MODE_BOTH_OUT: cmp_routed = 2'b11;
        `PFGAM_CMP_MODE_C1_OUT:   cmp_routed = 2'b01;
        default:                  cmp_routed = 2'b00;
      endcase
    end
  endfunction

  function is_offset;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      is_offset = (addr == ofs);
    end
  endfunction

  // ========================================================================
  // Storage
  reg  [7:0]                   latch_reg;
  reg  [7:0]                   direction_reg;
  reg  [`PFGAM_ADC_CFG_W-1:0]  adc_cfg_reg;
  reg  [`PFGAM_CMP_CFG_W-1:0]  cmp_cfg_reg;
  reg  [7:0]                   vref_reg;

  wire [7:0]                   pin_sync;
  wire [1:0]                   cmp_sync;

  // Bit 0 only exists in the wide variant
  wire [7:0]                   impl_mask = (WIDE_VARIANT != 0) ? 8'hFF : 8'hFE;

  // Both synchroniser stages reset low, so the select output waits until
  // they hold real pin levels; otherwise it would pulse active after reset.
  reg  [1:0]                   sync_fill_reg;

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync_fill_reg <= 2'b00;
    end
    else if (clk_en)
    begin
      sync_fill_reg <= {sync_fill_reg[0], 1'b1};
    end
  end

  pfgam_sync
  #(
    .WIDTH (10)
  )
  u_sync
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .async_in ({second_comparator_output, first_comparator_output, pin_in}),
    .sync_out ({cmp_sync, pin_sync})
  );

  // ========================================================================
  // Pin function decode
  reg  [7:0] analog_sel;
  reg  [7:0] digin_off;
  reg  [7:0] drive_en;
  reg  [7:0] drive_val;
  reg  [7:0] port_read;
  reg  [1:0] routed;
  reg        cmp_on;
  reg        vref_oe;

  always @*
  begin
    routed     = cmp_routed(cmp_cfg_reg[`PFGAM_CMP_MODE_MSB:0]);
    cmp_on     = cmp_cfg_reg[`PFGAM_CMP_MODE_MSB:0] != `PFGAM_CMP_MODE_OFF;
    vref_oe    = vref_reg[`PFGAM_VREF_OE_BIT];
    analog_sel = {1'b0, pcfg_analog(adc_cfg_reg[`PFGAM_PCFG_MSB:0])} & impl_mask;
    // Comparator inputs on pins 3..6 also cut the digital input path
    digin_off  = analog_sel | ({1'b0, {4{cmp_on}}, 3'b000});
    // Drive follows the latch regardless of analog selection
    drive_en   = ~direction_reg & impl_mask;
    drive_val  = latch_reg;
    if (routed[1])
    begin
      drive_val[`PFGAM_SECOND_COMPARATOR_OUTPUT_PIN] = cmp_sync[1];
    end
    if (routed[0])
    begin
      drive_val[`PFGAM_FIRST_COMPARATOR_OUTPUT_PIN] = cmp_sync[0];
    end
    if (vref_oe)
    begin
      drive_en[`PFGAM_VREF_PIN]  = 1'b0;
      digin_off[`PFGAM_VREF_PIN] = 1'b1;
    end
    // Pins with the input path off read as 0
    port_read  = pin_sync & ~digin_off & impl_mask;
  end

  // ========================================================================
  // APB slave: one wait state, so reads always see settled register values
  wire       setup_phase  = psel & ~penable;
  wire       access_phase = psel & penable;
  wire       commit       = access_phase & pready;
  reg        hit;
  reg [31:0] rd_word;

  always @*
  begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      `PFGAM_OFS_PIN_VALUE:     rd_word[7:0] = port_read;
      `PFGAM_OFS_OUTPUT_LATCH:  rd_word[7:0] = latch_reg & impl_mask;
      `PFGAM_OFS_DIRECTION:     rd_word[7:0] = direction_reg & impl_mask;
      `PFGAM_OFS_ADC_PIN_CFG:   rd_word[`PFGAM_ADC_CFG_W-1:0] = adc_cfg_reg;
      `PFGAM_OFS_CMP_CONTROL:   rd_word[7:0] = {cmp_sync[1], cmp_sync[0], cmp_cfg_reg};
      `PFGAM_OFS_CMP_VREF_CTRL: rd_word[7:0] = vref_reg;
      default:                  hit = 1'b0;
    endcase
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      if (access_phase && !pready)
      begin
        pready  <= 1'b1;
        pslverr <= ~hit;
        prdata  <= pwrite ? 32'h0000_0000 : rd_word;
      end
      else
      begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        if (setup_phase)
        begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ========================================================================
  // Register writes, taken at the completing edge of the access phase
  wire wr_en = commit & pwrite;

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      latch_reg     <= `PFGAM_RST_LATCH;
      direction_reg <= `PFGAM_RST_DIRECTION;
      adc_cfg_reg   <= `PFGAM_RST_ADC_PIN_CFG;
      cmp_cfg_reg   <= `PFGAM_RST_CMP_CONTROL;
      vref_reg      <= `PFGAM_RST_VREF_CTRL;
    end
    else if (clk_en && wr_en)
    begin
      // Writing the port register lands in the latch, as on real ports
      if (is_offset(paddr, `PFGAM_OFS_PIN_VALUE) || is_offset(paddr, `PFGAM_OFS_OUTPUT_LATCH))
      begin
        latch_reg <= pwdata[7:0] & impl_mask;
      end
      if (is_offset(paddr, `PFGAM_OFS_DIRECTION))
      begin
        // Absent bit 0 stays an input so it never drives
        direction_reg <= pwdata[7:0] | ~impl_mask;
      end
      if (is_offset(paddr, `PFGAM_OFS_ADC_PIN_CFG))
      begin
        adc_cfg_reg <= pwdata[`PFGAM_ADC_CFG_W-1:0];
      end
      if (is_offset(paddr, `PFGAM_OFS_CMP_CONTROL))
      begin
        // Comparator result bits are read-only
        cmp_cfg_reg <= pwdata[`PFGAM_CMP_CFG_W-1:0];
      end
      if (is_offset(paddr, `PFGAM_OFS_CMP_VREF_CTRL))
      begin
        vref_reg <= pwdata[7:0];
      end
    end
  end

  // ========================================================================
  // Registered pin and peripheral outputs
  // One cycle behind the registers; glitch-free pins were preferred to
  // zero latency.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_out                  <= 8'h00;
      pin_oe                   <= 8'h00;
      analog_enable            <= 8'h00;
      comparator_input_connect <= 4'h0;
      comparator_config        <= 6'h00;
      vref_config              <= 8'h00;
      vref_output_enable       <= 1'b0;
      serial_slave_select      <= 1'b1;
    end
    else if (clk_en)
    begin
      pin_out                  <= drive_val & drive_en;
      pin_oe                   <= drive_en;
      analog_enable            <= analog_sel;
      // Bit 0 is pin 3 (second plus) up to bit 3, pin 6 (first minus)
      comparator_input_connect <= {analog_sel[6], analog_sel[5], analog_sel[4], analog_sel[3]} & {4{cmp_on}};
      comparator_config        <= cmp_cfg_reg;
      vref_config              <= vref_reg;
      vref_output_enable       <= vref_oe;
      // Inactive high when the pin is an output
      serial_slave_select      <= (direction_reg[`PFGAM_SS_PIN] & sync_fill_reg[1]) ? pin_sync[`PFGAM_SS_PIN] : 1'b1;
    end
  end

endmodule

// [hw/pfgam_sync.v]
/*
  Two flip-flop synchroniser for a vector of asynchronous levels.
  Assumes core_clk domain, active-low asynchronous reset, and a clock
  enable that freezes both stages while low.
*/
`timescale 1ns/1ps

module pfgam_sync
#(
  parameter WIDTH = 8
)
(
  input  wire             core_clk,
  input  wire             resetn,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // ========================================================================
  // Per-bit stages; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg meta_reg;
      reg stable_reg;
      always @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          meta_reg   <= 1'b0;
          stable_reg <= 1'b0;
        end
        else if (clk_en)
        begin
          meta_reg   <= async_in[i];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[i] = stable_reg;
    end
  endgenerate

endmodule

// [test/pfgam_pins.sv]
/*
  Board side of the port: pin wires resolving port drive against external levels.
  Assumes the bench sets the external level of every undriven pin.
*/
`timescale 1ns/1ps

module pfgam_pins
(
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe,
  input  wire [7:0] ext_level,
  output wire [7:0] pin_in
);
  // ==========================================
  // Pin wire: the port wins where it drives
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

// [test/pfgam_port_sva.sv]
/*
  Concurrent checks on the port's APB and pin outputs.
  Assumes one clock domain and the top module's port names.
*/
`timescale 1ns/1ps

module pfgam_port_sva
(
  input wire        core_clk,
  input wire        resetn,
  input wire        clk_en,
  input wire        psel,
  input wire        penable,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [7:0]  pin_out,
  input wire [7:0]  pin_oe,
  input wire [7:0]  analog_enable,
  input wire [3:0]  comparator_input_connect,
  input wire [5:0]  comparator_config,
  input wire        vref_output_enable,
  input wire        serial_slave_select
);
  // ==========================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_ready_pulse: assert property (pready && clk_en |=> !pready) else $error("pready held");
  a_ready_wait: assert property (psel && clk_en && $rose(penable) |=> pready) else $error("no answer");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable)) else $error("stray pready");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  a_drive_gated: assert property ((pin_out & ~pin_oe) == 8'h0) else $error("undriven pin high");
  a_vref_drive: assert property (vref_output_enable && $past(vref_output_enable) |-> !pin_oe[5])
    else $error("pin 5 driven under reference");
  a_pin7_digital: assert property (!analog_enable[7]) else $error("pin 7 analog");
  a_ss_idle: assert property (pin_oe[7] && $past(pin_oe[7]) |-> serial_slave_select)
    else $error("select active on output");
  a_cmp_off: assert property (comparator_config[2:0] == 3'h7 |-> comparator_input_connect == 4'h0)
    else $error("inputs fed while off");
endmodule

bind pfgam_port pfgam_port_sva u_sva (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
  .analog_enable(analog_enable), .comparator_input_connect(comparator_input_connect),
  .comparator_config(comparator_config), .vref_output_enable(vref_output_enable),
  .serial_slave_select(serial_slave_select));

// [test/test_port_f_gpio_with_analog_mux.sv]
/*
  Self-checking bench for the port: APB master tasks and scenarios.
  Assumes a 1 wait state slave and 2 synchroniser stages on inputs.
*/
`timescale 1ns/1ps

module test_port_f_gpio_with_analog_mux;
  logic core_clk, resetn, psel, penable, pwrite, c1, c2, pready, pslverr, vref_output_enable, serial_slave_select;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  pin_in, pin_out, pin_oe, ext, analog_enable, vref_config;
  logic [3:0]  comparator_input_connect;
  logic [5:0]  comparator_config;
  int          fail_count, samples_checked, cycles;
  logic        clk_en;

  pfgam_port dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .first_comparator_output(c1),
    .second_comparator_output(c2), .analog_enable(analog_enable),
    .comparator_input_connect(comparator_input_connect), .comparator_config(comparator_config),
    .vref_config(vref_config), .vref_output_enable(vref_output_enable),
    .serial_slave_select(serial_slave_select));
  pfgam_pins board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

  // ==========================================
  // Checking and APB tasks
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    // Read data only counts at the edge that saw pready
    rd = pslverr ? 32'hFFFFFFFF : prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  task settle();
    // One cycle to the outputs plus two synchroniser stages
    repeat (4) @(posedge core_clk);
  endtask

  // ==========================================
  // Scenarios
  task t_reset();
    rchk(12'h008, 32'hFF, "dir reset");
    rchk(12'h004, 32'h00, "latch reset");
    rchk(12'h000, 32'h80, "analog pins read 0");
    chk(analog_enable, 8'h7F, "analog default");
    chk(pin_oe, 8'h00, "all inputs");
    apb(1'b1, 12'h018, 32'h55);
    chk(rd, 32'hFFFFFFFF, "unmapped refused");
  endtask

  task t_digital();
    apb(1'b1, 12'h010, 32'h07);
    apb(1'b1, 12'h00C, 32'h0F);
    ext <= 8'h0C;
    apb(1'b1, 12'h000, 32'h5A);
    apb(1'b1, 12'h008, 32'h0F);
    settle();
    chk(analog_enable, 8'h00, "digital pins");
    chk({pin_oe, pin_out}, 16'hF050, "drive");
    rchk(12'h000, 32'h5C, "mixed read");
    rchk(12'h004, 32'h5A, "latch read");
    chk(serial_slave_select, 1'b1, "select idle");
    ext <= 8'h7F;
    apb(1'b1, 12'h008, 32'hFF);
    settle();
    rchk(12'h000, 32'h7F, "input read");
    chk(serial_slave_select, 1'b0, "select follows pin");
  endtask

  task t_freeze();
    clk_en <= 1'b0;
    ext    <= 8'hFF;
    settle();
    chk(serial_slave_select, 1'b0, "frozen while disabled");
    clk_en <= 1'b1;
    settle();
    chk(serial_slave_select, 1'b1, "select released");
  endtask

  task t_analog();
    apb(1'b1, 12'h00C, 32'h00);
    apb(1'b1, 12'h004, 32'h3C);
    apb(1'b1, 12'h008, 32'h00);
    settle();
    chk({pin_oe, pin_out}, 16'hFF3C, "drive while analog");
    ext <= 8'hFF;
    apb(1'b1, 12'h008, 32'hFF);
    settle();
    rchk(12'h000, 32'h80, "input off while analog");
  endtask

  task t_vref();
    apb(1'b1, 12'h00C, 32'h0F);
    apb(1'b1, 12'h008, 32'hDF);
    apb(1'b1, 12'h014, 32'h40);
    settle();
    chk({vref_output_enable, pin_oe}, 9'h100, "reference owns pin 5");
    apb(1'b1, 12'h008, 32'hFF);
    settle();
    rchk(12'h000, 32'hDF, "pin 5 input off");
    apb(1'b1, 12'h014, 32'h00);
  endtask

  task t_cmp();
    apb(1'b1, 12'h004, 32'h00);
    apb(1'b1, 12'h010, 32'h03);
    apb(1'b1, 12'h008, 32'h00);
    c1 <= 1'b1;
    c2 <= 1'b0;
    settle();
    chk(pin_out[2:1], 2'b10, "outputs routed");
    rchk(12'h010, 32'h43, "result bits");
    c1 <= 1'b0;
    c2 <= 1'b1;
    settle();
    chk(pin_out[2:1], 2'b01, "outputs follow");
    apb(1'b1, 12'h010, 32'h05);
    c1 <= 1'b1;
    settle();
    chk(pin_out[2:1], 2'b10, "first routed only");
    apb(1'b1, 12'h00C, 32'h00);
    settle();
    chk(comparator_input_connect, 4'hF, "inputs fed");
    apb(1'b1, 12'h010, 32'h07);
    settle();
    chk(comparator_input_connect, 4'h0, "inputs released");
  endtask

  task t_rerun();
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rchk(12'h008, 32'hFF, "dir after second reset");
    chk(analog_enable, 8'h7F, "analog after second reset");
    rchk(12'h000, 32'h80, "analog pins read 0 again");
  endtask

  // ==========================================
  // Run control
  task final_report();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  initial
  begin
    {resetn, psel, penable, pwrite, c1, c2} = 6'h0;
    clk_en = 1'b1;
    paddr = 12'h0;
    pwdata = 32'h0;
    ext = 8'hFF;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_digital();
    t_freeze();
    t_analog();
    t_vref();
    t_cmp();
    t_rerun();
    final_report();
  end
endmodule
